// ===== logic/hcm_mailbox.sv
// Host command mailbox: command interpreter behind two host registers.
// ----------------------------------------------------------------------
// Summary of operation
// - Command byte goes to configuration register, parameter to 2DBh.
// - Response bytes are placed in the parameter/response register.
// - Valid command bytes carry the pending bit set.
// - On completion prior configuration is restored, clearing pending.
// - Commands 10 and 11 load counter low and high bytes.
// - Command 12 writes parameter into memory at the counter.
// - Command 13 loads parameter into the control register.
// - Commands 18 and 19 return counter low and high bytes.
// - Command 1A returns the memory byte at the counter.
// - Command 1B returns one revision byte.
// - Command 30 clears all six receiver error counters.
// - Commands 31 and 32 return disable and mid-bit loss counts.
// - Commands 33 and 34 return bad ending and parity counts.
// - Commands 35 and 36 return overflow and protocol counts.
// - Memory commands reach every byte of the data memory.
// - Commands run while the processor keeps using its memory port.
// - Counter increments after memory commands only if control bit 0.
// - The address counter is 16 bits wide.
// - Unused command codes change no state.
// - Revision byte is two zero bits, position count, BCD digit.
// ----------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module hcm_mailbox
	import hcm_pkg::*;
(
	input wire logic clk_sys, // System clock, 200 MHz.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic [9:0] hostAddr, // Host I/O address.
	input wire logic hostWrEn, // Host write strobe, one cycle.
	input wire logic hostRdEn, // Host read strobe, one cycle.
	input wire logic [7:0] hostWrData, // Host write data.
	output logic [7:0] hostRdData, // Host read data, next cycle.
	input wire logic [5:0] errEvent, // Receiver error pulses.
	input wire logic [15:0] procAddr, // Processor memory address.
	input wire logic procWrEn, // Processor memory write strobe.
	input wire logic [7:0] procWrData, // Processor memory write data.
	output logic [7:0] procRdData, // Processor memory read data.
	output logic [7:0] controlReg, // Control register value.
	output logic cmdPending // Command in progress.
);

	hcm_regs_t s_r;
	hcm_regs_t s_nxt;
	logic memWrEn;
	logic [7:0] memRdData;
	logic clrErr;
	logic finish;
	logic [2:0] errSel;
	logic [3:0] revDigit;

	// ------------------------------------------------------------------
	// Data memory
	// ------------------------------------------------------------------
	// full address space
	hcm_data_mem u_mem (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.aAddr(procAddr),
		.aWrEn(procWrEn),
		.aWrData(procWrData),
		.aRdData(procRdData),
		.bAddr(s_r.counter),
		.bWrEn(memWrEn),
		.bWrData(s_r.param),
		.bRdData(memRdData)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		memWrEn = 1'b0;
		clrErr = 1'b0;
		finish = 1'b0;
		errSel = 3'(s_r.cmd - HCM_CMD_ERR_FIRST);
		case (s_r.revIdx)
			2'h0: revDigit = HCM_REV_DIGIT0;
			2'h1: revDigit = HCM_REV_DIGIT1;
			default: revDigit = HCM_REV_DIGIT2;
		endcase
		if (hostRdEn) begin
			if (hostAddr == HCM_PARAM_RESP_OFS) begin
				s_nxt.rdData = s_r.param;
			end else if (hostAddr == HCM_CONFIG_CMD_OFS) begin
				s_nxt.rdData = s_r.cfg;
			end else begin
				s_nxt.rdData = 8'h00;
			end
		end
		case (s_r.state)
			HCM_IDLE: begin
				// Host writes are taken only while no command is running.
				// host register writes
				if (hostWrEn && hostAddr == HCM_PARAM_RESP_OFS) begin
					s_nxt.param = hostWrData;
				end else if (hostWrEn && hostAddr == HCM_CONFIG_CMD_OFS) begin
					s_nxt.cfg = hostWrData;
					if (hostWrData[HCM_PEND_BIT]) begin
						s_nxt.savedCfg = s_r.cfg;
						s_nxt.cmd = hostWrData;
						s_nxt.state = HCM_EXEC;
					end
				end
			end
			HCM_EXEC: begin
				finish = 1'b1;
				if (s_r.cmd == HCM_CMD_LOAD_LOW) begin
					s_nxt.counter[7:0] = s_r.param;
				end else if (s_r.cmd == HCM_CMD_LOAD_HIGH) begin
					s_nxt.counter[15:8] = s_r.param;
				end else if (s_r.cmd == HCM_CMD_MEM_WRITE) begin
					memWrEn = 1'b1;
					if (s_r.ctrl[HCM_AUTOINC_BIT]) begin
						s_nxt.counter = s_r.counter + 16'h0001;
					end
				end else if (s_r.cmd == HCM_CMD_LOAD_CTRL) begin
					s_nxt.ctrl = s_r.param;
				end else if (s_r.cmd == HCM_CMD_READ_LOW) begin
					s_nxt.param = s_r.counter[7:0];
				end else if (s_r.cmd == HCM_CMD_READ_HIGH) begin
					s_nxt.param = s_r.counter[15:8];
				end else if (s_r.cmd == HCM_CMD_MEM_READ) begin
					finish = 1'b0;
					s_nxt.state = HCM_MEMRD;
				end else if (s_r.cmd == HCM_CMD_REVISION) begin
					s_nxt.param = {2'b00, s_r.revIdx + 2'h1, revDigit};
					if (s_r.revIdx == HCM_REV_LAST_IDX) begin
						s_nxt.revIdx = 2'h0;
					end else begin
						s_nxt.revIdx = s_r.revIdx + 2'h1;
					end
				end else if (s_r.cmd == HCM_CMD_CLEAR_ERR) begin
					clrErr = 1'b1;
				end else if (s_r.cmd >= HCM_CMD_ERR_FIRST &&
					s_r.cmd <= HCM_CMD_ERR_LAST) begin
					s_nxt.param = s_r.errCnt[errSel];
				end
			end
			// The registered memory read adds one cycle to a read command.
			HCM_MEMRD: begin
				finish = 1'b1;
				s_nxt.param = memRdData;
				if (s_r.ctrl[HCM_AUTOINC_BIT]) begin
					s_nxt.counter = s_r.counter + 16'h0001;
				end
			end
			default: begin
				s_nxt.state = HCM_IDLE;
			end
		endcase
		if (finish) begin
			s_nxt.cfg = s_r.savedCfg;
			s_nxt.state = HCM_IDLE;
		end
		// An event in the clearing cycle is kept as a count of one.
		for (int i = 0; i < HCM_NUM_ERR; i++) begin
			if (clrErr) begin
				s_nxt.errCnt[i] = {7'h00, errEvent[i]};
			end else if (errEvent[i] && s_r.errCnt[i] != HCM_ERRCNT_MAX) begin
				s_nxt.errCnt[i] = s_r.errCnt[i] + 8'h01;
			end
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_r.state <= HCM_IDLE;
			s_r.cfg <= HCM_CONFIG_RST;
			s_r.savedCfg <= HCM_CONFIG_RST;
			s_r.param <= HCM_PARAM_RST;
			s_r.cmd <= 8'h00;
			s_r.counter <= HCM_COUNTER_RST;
			s_r.ctrl <= HCM_CONTROL_RST;
			s_r.revIdx <= 2'h0;
			s_r.errCnt <= {HCM_NUM_ERR{HCM_ERRCNT_RST}};
			s_r.rdData <= 8'h00;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign hostRdData = s_r.rdData;
	assign controlReg = s_r.ctrl;
	assign cmdPending = s_r.cfg[HCM_PEND_BIT];

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	logic cmdWrite;
	assign cmdWrite = s_r.state == HCM_IDLE && hostWrEn &&
		hostAddr == HCM_CONFIG_CMD_OFS && hostWrData[HCM_PEND_BIT];

	chk_cmd_start: assert property (
		cmdWrite |=> s_r.state == HCM_EXEC && s_r.cmd == $past(hostWrData))
		else $error("command write did not start execution");

	chk_busy_bounded: assert property (
		$rose(s_r.state != HCM_IDLE) |-> ##[1:2] s_r.state == HCM_IDLE)
		else $error("command did not complete in time");

	chk_cfg_restore: assert property (
		cmdWrite |=> ##[1:2] s_r.cfg == $past(s_r.cfg, 2) ||
		s_r.cfg == $past(s_r.cfg, 3))
		else $error("configuration not restored");

	chk_load_low: assert property (
		s_r.state == HCM_EXEC && s_r.cmd == HCM_CMD_LOAD_LOW |=>
		s_r.counter[7:0] == $past(s_r.param) &&
		$stable(s_r.counter[15:8]))
		else $error("counter low byte not loaded");

	chk_load_high: assert property (
		s_r.state == HCM_EXEC && s_r.cmd == HCM_CMD_LOAD_HIGH |=>
		s_r.counter[15:8] == $past(s_r.param) &&
		$stable(s_r.counter[7:0]))
		else $error("counter high byte not loaded");

	chk_load_ctrl: assert property (
		s_r.state == HCM_EXEC && s_r.cmd == HCM_CMD_LOAD_CTRL |=>
		controlReg == $past(s_r.param))
		else $error("control register not loaded");

	chk_read_low: assert property (
		s_r.state == HCM_EXEC && s_r.cmd == HCM_CMD_READ_LOW |=>
		s_r.param == $past(s_r.counter[7:0]))
		else $error("counter low byte not returned");

	chk_read_high: assert property (
		s_r.state == HCM_EXEC && s_r.cmd == HCM_CMD_READ_HIGH |=>
		s_r.param == $past(s_r.counter[15:8]))
		else $error("counter high byte not returned");

	chk_idle_clear: assert property (
		s_r.state == HCM_IDLE |-> !cmdPending)
		else $error("pending bit set while idle");

	chk_save_prior: assert property (
		cmdWrite |=> s_r.savedCfg == $past(s_r.cfg))
		else $error("prior configuration not saved");

	chk_write_inc: assert property (
		s_r.state == HCM_EXEC && s_r.cmd == HCM_CMD_MEM_WRITE |=>
		s_r.counter == $past(s_r.counter) +
		16'($past(s_r.ctrl[HCM_AUTOINC_BIT])))
		else $error("counter step after write is wrong");

	chk_read_resp: assert property (
		s_r.state == HCM_EXEC && s_r.cmd == HCM_CMD_MEM_READ |=> ##1
		s_r.param == $past(memRdData) && !cmdPending)
		else $error("memory read response wrong");

	chk_rev_format: assert property (
		s_r.state == HCM_EXEC && s_r.cmd == HCM_CMD_REVISION |=>
		s_r.param[7:6] == 2'b00 && s_r.param[5:4] != 2'b00)
		else $error("revision byte badly formed");

	chk_err_clear: assert property (
		s_r.state == HCM_EXEC && s_r.cmd == HCM_CMD_CLEAR_ERR &&
		errEvent == 6'h00 |=> s_r.errCnt == '0)
		else $error("error counters not cleared");

	chk_unused_cmd: assert property (
		s_r.state == HCM_EXEC && s_r.cmd == 8'h1f |=>
		$stable(s_r.counter) && $stable(s_r.ctrl) && $stable(s_r.param))
		else $error("unused command changed state");

	cov_mem_read: cover property (
		s_r.state == HCM_EXEC && s_r.cmd == HCM_CMD_MEM_READ);
	cov_mem_write_inc: cover property (
		s_r.state == HCM_EXEC && s_r.cmd == HCM_CMD_MEM_WRITE &&
		s_r.ctrl[HCM_AUTOINC_BIT]);
	cov_rev_wrap: cover property (
		s_r.state == HCM_EXEC && s_r.cmd == HCM_CMD_REVISION &&
		s_r.revIdx == HCM_REV_LAST_IDX);
	cov_err_read: cover property (
		s_r.state == HCM_EXEC && s_r.cmd == HCM_CMD_ERR_LAST);

endmodule
`default_nettype wire

// ===== logic/hcm_pkg.sv
// Package of constants and types for the host command mailbox.
package hcm_pkg;

	// ------------------------------------------------------------------
	// Host register map
	// ------------------------------------------------------------------
	localparam logic [9:0] HCM_PARAM_RESP_OFS = 10'h2db;
	localparam logic [9:0] HCM_CONFIG_CMD_OFS = 10'h2dc;
	localparam logic [7:0] HCM_CONFIG_RST = 8'h00;
	localparam logic [7:0] HCM_PARAM_RST = 8'h00;
	localparam logic [7:0] HCM_CONTROL_RST = 8'h00;
	localparam logic [15:0] HCM_COUNTER_RST = 16'h0000;
	localparam logic [7:0] HCM_ERRCNT_RST = 8'h00;
	localparam logic [7:0] HCM_ERRCNT_MAX = 8'hff;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int HCM_PEND_BIT = 4;
	localparam int HCM_AUTOINC_BIT = 0;
	localparam int HCM_ADDR_W = 16;
	localparam int HCM_MEM_DEPTH = 65536;
	localparam int HCM_NUM_ERR = 6;

	// ------------------------------------------------------------------
	// Command codes
	// ------------------------------------------------------------------
	localparam logic [7:0] HCM_CMD_LOAD_LOW = 8'h10;
	localparam logic [7:0] HCM_CMD_LOAD_HIGH = 8'h11;
	localparam logic [7:0] HCM_CMD_MEM_WRITE = 8'h12;
	localparam logic [7:0] HCM_CMD_LOAD_CTRL = 8'h13;
	localparam logic [7:0] HCM_CMD_READ_LOW = 8'h18;
	localparam logic [7:0] HCM_CMD_READ_HIGH = 8'h19;
	localparam logic [7:0] HCM_CMD_MEM_READ = 8'h1a;
	localparam logic [7:0] HCM_CMD_REVISION = 8'h1b;
	localparam logic [7:0] HCM_CMD_CLEAR_ERR = 8'h30;
	localparam logic [7:0] HCM_CMD_ERR_FIRST = 8'h31;
	localparam logic [7:0] HCM_CMD_ERR_LAST = 8'h36;

	// ------------------------------------------------------------------
	// Revision digits, most significant first (values are arbitrary)
	// ------------------------------------------------------------------
	localparam logic [3:0] HCM_REV_DIGIT0 = 4'h1;
	localparam logic [3:0] HCM_REV_DIGIT1 = 4'h0;
	localparam logic [3:0] HCM_REV_DIGIT2 = 4'h0;
	localparam logic [1:0] HCM_REV_LAST_IDX = 2'h2;

	typedef enum logic [1:0] {
		HCM_IDLE,
		HCM_EXEC,
		HCM_MEMRD
	} hcm_state_t;

	typedef struct packed {
		hcm_state_t state;
		logic [7:0] cfg;
		logic [7:0] savedCfg;
		logic [7:0] param;
		logic [7:0] cmd;
		logic [15:0] counter;
		logic [7:0] ctrl;
		logic [1:0] revIdx;
		logic [5:0][7:0] errCnt;
		logic [7:0] rdData;
	} hcm_regs_t;

endpackage

// ===== logic/hcm_data_mem.sv
// Dual-port byte memory with registered read data on both ports.
`timescale 1ns/10ps
`default_nettype none
module hcm_data_mem
	import hcm_pkg::*;
(
	input wire logic clk_sys, // System clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic [15:0] aAddr, // Port A address.
	input wire logic aWrEn, // Port A write strobe.
	input wire logic [7:0] aWrData, // Port A write data.
	output logic [7:0] aRdData, // Port A read data, registered.
	input wire logic [15:0] bAddr, // Port B address.
	input wire logic bWrEn, // Port B write strobe.
	input wire logic [7:0] bWrData, // Port B write data.
	output logic [7:0] bRdData // Port B read data, registered.
);

	logic [7:0] mem [HCM_MEM_DEPTH];

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (aWrEn) begin
			mem[aAddr] <= aWrData;
		end
		if (bWrEn) begin
			mem[bAddr] <= bWrData;
		end
	end

	// ------------------------------------------------------------------
	// Read registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			aRdData <= 8'h00;
			bRdData <= 8'h00;
		end else begin
			aRdData <= mem[aAddr];
			bRdData <= mem[bAddr];
		end
	end

endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking testbench of the host command mailbox.
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import hcm_pkg::*;
;
	logic clk_sys;
	logic rst_n;
	logic [9:0] hostAddr;
	logic hostWrEn;
	logic hostRdEn;
	logic [7:0] hostWrData;
	logic [7:0] hostRdData;
	logic [5:0] errEvent;
	logic [15:0] procAddr;
	logic procWrEn;
	logic [7:0] procWrData;
	logic [7:0] procRdData;
	logic [7:0] controlReg;
	logic cmdPending;
	logic [7:0] cfgShadow;
	logic [7:0] rsp;
	int errTotal;
	int numChecks;

	hcm_mailbox dut (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.hostAddr(hostAddr),
		.hostWrEn(hostWrEn),
		.hostRdEn(hostRdEn),
		.hostWrData(hostWrData),
		.hostRdData(hostRdData),
		.errEvent(errEvent),
		.procAddr(procAddr),
		.procWrEn(procWrEn),
		.procWrData(procWrData),
		.procRdData(procRdData),
		.controlReg(controlReg),
		.cmdPending(cmdPending)
	);

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// ------------------------------------------------------------------
	// Host access and checking tasks
	// ------------------------------------------------------------------
	task automatic finishTest();
		$display("checks %0d, mismatches %0d", numChecks, errTotal);
		if (errTotal == 0 && numChecks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		numChecks++;
		if (got !== exp) begin
			errTotal++;
			$display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
		end
	endtask

	task automatic hostWrite(input logic [9:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		hostAddr = a;
		hostWrData = d;
		hostWrEn = 1'b1;
		@(negedge clk_sys);
		hostWrEn = 1'b0;
	endtask

	task automatic hostRead(input logic [9:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		hostAddr = a;
		hostRdEn = 1'b1;
		@(negedge clk_sys);
		hostRdEn = 1'b0;
		@(negedge clk_sys);
		d = hostRdData;
	endtask

	// Issues one command, polls for completion and fetches the response.
	task automatic runCmd(input logic [7:0] code, input logic [7:0] prm);
		logic [7:0] v;
		int n;
		hostWrite(HCM_PARAM_RESP_OFS, prm);
		hostWrite(HCM_CONFIG_CMD_OFS, code);
		check8({7'h00, cmdPending}, 8'h01);
		for (n = 0; n < 20; n++) begin
			hostRead(HCM_CONFIG_CMD_OFS, v);
			if (v[HCM_PEND_BIT] === 1'b0) break;
		end
		if (n == 20) begin
			errTotal++;
			$display("unexpected at %0t: command never completed", $time);
			finishTest();
		end
		check8(v, cfgShadow);
		hostRead(HCM_PARAM_RESP_OFS, rsp);
	endtask

	task automatic procRead(input logic [15:0] a, input logic [7:0] exp);
		@(negedge clk_sys);
		procAddr = a;
		@(negedge clk_sys);
		check8(procRdData, exp);
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		hostAddr = '0;
		hostWrEn = 1'b0;
		hostRdEn = 1'b0;
		hostWrData = '0;
		errEvent = '0;
		procAddr = '0;
		procWrEn = 1'b0;
		procWrData = '0;
		errTotal = 0;
		numChecks = 0;
		cfgShadow = HCM_CONFIG_RST;
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		hostRead(HCM_CONFIG_CMD_OFS, rsp);
		check8(rsp, HCM_CONFIG_RST);
		hostRead(HCM_PARAM_RESP_OFS, rsp);
		check8(rsp, HCM_PARAM_RST);
		check8(controlReg, HCM_CONTROL_RST);
		cfgShadow = 8'h05;
		hostWrite(HCM_CONFIG_CMD_OFS, cfgShadow);
		runCmd(HCM_CMD_LOAD_LOW, 8'hfe);
		runCmd(HCM_CMD_LOAD_HIGH, 8'hff);
		runCmd(HCM_CMD_READ_LOW, 8'h00);
		check8(rsp, 8'hfe);
		hostRead(10'h2da, rsp);
		check8(rsp, 8'h00);
		runCmd(HCM_CMD_READ_HIGH, 8'h00);
		check8(rsp, 8'hff);
		runCmd(HCM_CMD_LOAD_CTRL, 8'h01);
		check8(controlReg, 8'h01);
		runCmd(HCM_CMD_LOAD_LOW, 8'hff);
		runCmd(HCM_CMD_MEM_WRITE, 8'ha5);
		runCmd(HCM_CMD_MEM_WRITE, 8'h5a);
		runCmd(HCM_CMD_READ_LOW, 8'h00);
		check8(rsp, 8'h01);
		runCmd(HCM_CMD_READ_HIGH, 8'h00);
		check8(rsp, 8'h00);
		procRead(16'hffff, 8'ha5);
		procRead(16'h0000, 8'h5a);
		@(negedge clk_sys);
		procAddr = 16'h0001;
		procWrData = 8'h3c;
		procWrEn = 1'b1;
		@(negedge clk_sys);
		procWrEn = 1'b0;
		runCmd(HCM_CMD_MEM_READ, 8'h00);
		check8(rsp, 8'h3c);
		runCmd(HCM_CMD_READ_LOW, 8'h00);
		check8(rsp, 8'h02);
		runCmd(HCM_CMD_LOAD_CTRL, 8'h00);
		check8(controlReg, 8'h00);
		runCmd(HCM_CMD_LOAD_LOW, 8'h00);
		runCmd(HCM_CMD_MEM_READ, 8'h00);
		check8(rsp, 8'h5a);
		runCmd(8'h1f, 8'h77);
		runCmd(HCM_CMD_READ_LOW, 8'h00);
		check8(rsp, 8'h00);
		check8(controlReg, 8'h00);
		runCmd(HCM_CMD_REVISION, 8'h00);
		check8(rsp, {2'b00, 2'd1, HCM_REV_DIGIT0});
		runCmd(HCM_CMD_REVISION, 8'h00);
		check8(rsp, {2'b00, 2'd2, HCM_REV_DIGIT1});
		runCmd(HCM_CMD_REVISION, 8'h00);
		check8(rsp, {2'b00, 2'd3, HCM_REV_DIGIT2});
		for (int i = 0; i < HCM_NUM_ERR; i++) begin
			repeat (i + 1) begin
				@(negedge clk_sys);
				errEvent[i] = 1'b1;
				@(negedge clk_sys);
				errEvent[i] = 1'b0;
			end
		end
		for (int i = 0; i < HCM_NUM_ERR; i++) begin
			runCmd(HCM_CMD_ERR_FIRST + 8'(i), 8'h00);
			check8(rsp, 8'(i + 1));
		end
		runCmd(HCM_CMD_CLEAR_ERR, 8'h00);
		for (int i = 0; i < HCM_NUM_ERR; i++) begin
			runCmd(HCM_CMD_ERR_FIRST + 8'(i), 8'h00);
			check8(rsp, HCM_ERRCNT_RST);
		end
		check8({7'h00, cmdPending}, 8'h00);
		finishTest();
	end
endmodule
`default_nettype wire
